// File: hw/ssrc_pkg.sv
// Package with offsets, fields, reset values and rate tables of the secondary rate register.
package ssrc_pkg;
	localparam logic [7:0] SSRC_OFFSET = 8'h33;
	localparam logic [7:0] SSRC_RESET = 8'h00;
	localparam int SSRC_CODE_MSB = 7;
	localparam int SSRC_CODE_LSB = 2;
	localparam int SSRC_TOL_BIT = 1;
	localparam int SSRC_RSV_BIT = 0;
	localparam logic [5:0] SSRC_CODE_AUTO = 6'h00;
	localparam logic [5:0] SSRC_CODE_MAX = 6'h28;
	localparam int SSRC_TOL_NARROW_PCT = 1;
	localparam int SSRC_TOL_WIDE_PCT = 5;
	localparam int SSRC_RATE_W = 20;

	typedef enum logic [1:0] {SSRC_MODE_AUTO, SSRC_MODE_FIXED, SSRC_MODE_RESERVED} ssrc_mode_t;

	// Nominal rate for each code, with its lowest and highest accepted frequency.
	function automatic logic [3*SSRC_RATE_W-1:0] ssrc_rate_entry(input logic [5:0] code);
		logic [3*SSRC_RATE_W-1:0] e;
		e = '0;
		unique case (code)
			6'h01: e = {20'd768000, 20'd670320, 20'd791040};
			6'h02: e = {20'd614400, 20'd536256, 20'd632832};
			6'h03: e = {20'd512000, 20'd446880, 20'd527360};
			6'h04: e = {20'd438857, 20'd383040, 20'd452022};
			6'h05: e = {20'd384000, 20'd335160, 20'd395520};
			6'h06: e = {20'd341333, 20'd297920, 20'd351573};
			6'h07: e = {20'd307200, 20'd268128, 20'd316416};
			6'h08: e = {20'd256000, 20'd223440, 20'd263680};
			6'h09: e = {20'd219429, 20'd191520, 20'd226011};
			6'h0A: e = {20'd192000, 20'd167580, 20'd197760};
			6'h0B: e = {20'd170667, 20'd148960, 20'd175786};
			6'h0C: e = {20'd153600, 20'd134064, 20'd158208};
			6'h0D: e = {20'd128000, 20'd111720, 20'd131840};
			6'h0E: e = {20'd109714, 20'd95760, 20'd113005};
			6'h0F: e = {20'd96000, 20'd83790, 20'd98880};
			6'h10: e = {20'd85333, 20'd74480, 20'd87893};
			6'h11: e = {20'd76800, 20'd67032, 20'd79104};
			6'h12: e = {20'd64000, 20'd55860, 20'd65920};
			6'h13: e = {20'd54857, 20'd47880, 20'd56602};
			6'h14: e = {20'd48000, 20'd41895, 20'd49440};
			6'h15: e = {20'd42667, 20'd37240, 20'd43946};
			6'h16: e = {20'd38400, 20'd33516, 20'd39552};
			6'h17: e = {20'd32000, 20'd27930, 20'd32960};
			6'h18: e = {20'd27429, 20'd23940, 20'd28251};
			6'h19: e = {20'd24000, 20'd20947, 20'd24720};
			6'h1A: e = {20'd21333, 20'd18620, 20'd21973};
			6'h1B: e = {20'd19200, 20'd16758, 20'd19776};
			6'h1C: e = {20'd16000, 20'd13965, 20'd16480};
			6'h1D: e = {20'd13714, 20'd11970, 20'd14125};
			6'h1E: e = {20'd12000, 20'd10473, 20'd12360};
			6'h1F: e = {20'd10667, 20'd9310, 20'd10986};
			6'h20: e = {20'd9600, 20'd8379, 20'd9888};
			6'h21: e = {20'd8000, 20'd6982, 20'd8240};
			6'h22: e = {20'd6857, 20'd5985, 20'd7062};
			6'h23: e = {20'd6000, 20'd5236, 20'd6180};
			6'h24: e = {20'd5333, 20'd4655, 20'd5493};
			6'h25: e = {20'd4800, 20'd4189, 20'd4944};
			6'h26: e = {20'd4000, 20'd3491, 20'd4120};
			6'h27: e = {20'd3429, 20'd2992, 20'd3531};
			6'h28: e = {20'd3000, 20'd2618, 20'd3090};
			default: e = '0;
		endcase
		return e;
	endfunction : ssrc_rate_entry
endpackage : ssrc_pkg

// File: hw/ssrc_rate_lut.sv
// Lookup of nominal rate and accepted range for a secondary rate code.
`timescale 1ns/1ns
module ssrc_rate_lut
	import ssrc_pkg::*;
(
	input wire logic [5:0] code,
	output logic [SSRC_RATE_W-1:0] nominal_hz,
	output logic [SSRC_RATE_W-1:0] min_hz,
	output logic [SSRC_RATE_W-1:0] max_hz
);
	// Codes outside 1 to 40 give all-zero entries.
	always_comb
	begin
		{nominal_hz, min_hz, max_hz} = ssrc_rate_entry(code);
	end
endmodule : ssrc_rate_lut

// File: hw/ssrc_config.sv
// Secondary audio serial port rate configuration register and rate selection.
// What this block does
// RL1 - Register at offset 0x33, resets to zero.
// RL2 - Bits 7-2 rate code; zero means auto.
// RL3 - Codes 1-40 fix nominal rate and range.
// RL4 - Software must not write codes 41-63.
// RL5 - Bit 1 picks 1% or 5% tolerance.
// RL6 - Bit 0 reserved, reads zero.
// RL7 - Nonzero valid code overrides detected rate.
`timescale 1ns/1ns
module ssrc_config
	import ssrc_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [SSRC_RATE_W-1:0] detected_rate_hz,
	input wire logic detected_valid,
	output logic [7:0] reg_rdata,
	output logic [5:0] secondary_port_rate_code,
	output logic secondary_rate_tolerance_sel,
	output logic auto_detect_en,
	output logic [7:0] tolerance_pct,
	output logic code_reserved,
	output logic [SSRC_RATE_W-1:0] active_rate_hz,
	output logic [SSRC_RATE_W-1:0] active_min_hz,
	output logic [SSRC_RATE_W-1:0] active_max_hz,
	output logic active_rate_valid
);
	logic [5:0] code_r;
	logic tol_r;
	ssrc_mode_t mode;
	logic [SSRC_RATE_W-1:0] lut_nom;
	logic [SSRC_RATE_W-1:0] lut_min;
	logic [SSRC_RATE_W-1:0] lut_max;
	logic hit;

	// Only one address maps; writes elsewhere are ignored and reads elsewhere return zero.
	assign hit = (reg_addr == SSRC_OFFSET); // [RL1]

	// Writable fields; bit 0 is not stored so it always reads zero.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			code_r <= SSRC_RESET[SSRC_CODE_MSB:SSRC_CODE_LSB]; // [RL1]
			tol_r <= SSRC_RESET[SSRC_TOL_BIT];
		end
		else if (reg_wr_en && hit)
		begin
			code_r <= reg_wdata[SSRC_CODE_MSB:SSRC_CODE_LSB]; // [RL2]
			tol_r <= reg_wdata[SSRC_TOL_BIT]; // [RL5]
		end
	end

	// Read data is registered; unmapped addresses return zero.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd_en)
			reg_rdata <= hit ? {code_r, tol_r, 1'b0} : 8'h00; // [RL6]
	end

	ssrc_rate_lut u_ssrc_rate_lut (
		.code(code_r),
		.nominal_hz(lut_nom),
		.min_hz(lut_min),
		.max_hz(lut_max)
	);

	// Reserved codes are flagged rather than trusted, since software broke its side.
	always_comb
	begin
		if (code_r == SSRC_CODE_AUTO)
			mode = SSRC_MODE_AUTO; // [RL2]
		else if (code_r <= SSRC_CODE_MAX)
			mode = SSRC_MODE_FIXED; // [RL3]
		else
			mode = SSRC_MODE_RESERVED; // [RL4]
	end

	// Stored fields are mirrored to the clock logic, so they follow a register write by one cycle.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			secondary_port_rate_code <= SSRC_RESET[SSRC_CODE_MSB:SSRC_CODE_LSB]; // [RL1]
			secondary_rate_tolerance_sel <= SSRC_RESET[SSRC_TOL_BIT];
		end
		else
		begin
			secondary_port_rate_code <= code_r; // [RL2]
			secondary_rate_tolerance_sel <= tol_r; // [RL5]
		end
	end

	// Mode flags; reset leaves auto detection on because the code resets to zero.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			auto_detect_en <= 1'b1;
			code_reserved <= 1'b0;
		end
		else
		begin
			auto_detect_en <= (mode == SSRC_MODE_AUTO); // [RL2]
			code_reserved <= (mode == SSRC_MODE_RESERVED); // [RL4]
		end
	end

	// Tolerance in percent for the detector; it only matters while auto detection runs.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			tolerance_pct <= 8'(SSRC_TOL_NARROW_PCT);
		else
			tolerance_pct <= tol_r ? 8'(SSRC_TOL_WIDE_PCT) : 8'(SSRC_TOL_NARROW_PCT); // [RL5]
	end

	// Active rate; a fixed code wins over the detector, and a reserved code yields nothing usable.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			active_rate_hz <= '0;
			active_min_hz <= '0;
			active_max_hz <= '0;
			active_rate_valid <= 1'b0;
		end
		else
		begin
			unique case (mode)
				SSRC_MODE_FIXED:
				begin
					active_rate_hz <= lut_nom; // [RL7]
					active_min_hz <= lut_min; // [RL3]
					active_max_hz <= lut_max;
					active_rate_valid <= 1'b1;
				end
				SSRC_MODE_AUTO:
				begin
					active_rate_hz <= detected_rate_hz;
					active_min_hz <= '0;
					active_max_hz <= '0;
					active_rate_valid <= detected_valid;
				end
				default:
				begin
					active_rate_hz <= '0;
					active_min_hz <= '0;
					active_max_hz <= '0;
					active_rate_valid <= 1'b0;
				end
			endcase
		end
	end

	// Sampled arst_n in an antecedent skips the release edge, at which the flops still held reset.
	AST_RSV_ZERO: assert property (@(posedge mclk) disable iff (!arst_n) reg_rdata[SSRC_RSV_BIT] == 1'b0) // [RL6]
		else $error("Reserved bit read back nonzero.");
	AST_READBACK: assert property (@(posedge mclk) disable iff (!arst_n) // [RL1]
		reg_wr_en && hit ##1 reg_rd_en && hit && !reg_wr_en |=> reg_rdata == {$past(reg_wdata, 2) & 8'hFE})
		else $error("Read back differs from written value.");
	AST_AUTO_MODE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL2]
		arst_n && code_r == SSRC_CODE_AUTO && $stable(code_r)
		|=> auto_detect_en && active_rate_hz == $past(detected_rate_hz))
		else $error("Auto mode not taking detected rate.");
	AST_FIXED_RANGE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL3]
		code_r == 6'h01 |=> active_min_hz == 20'd670320 && active_max_hz == 20'd791040)
		else $error("Code one range wrong.");
	AST_LAST_CODE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL3]
		code_r == SSRC_CODE_MAX |=> active_rate_hz == 20'd3000)
		else $error("Code forty rate wrong.");
	AST_OVERRIDE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL7]
		code_r != SSRC_CODE_AUTO && code_r <= SSRC_CODE_MAX |=> !auto_detect_en && active_rate_valid)
		else $error("Fixed code did not override detection.");
	AST_TOLERANCE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL5]
		tol_r |=> tolerance_pct == 8'h05)
		else $error("Wide tolerance not applied.");
	AST_RESERVED_CODE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL4]
		code_r > SSRC_CODE_MAX |=> code_reserved && !active_rate_valid)
		else $error("Reserved code not flagged.");

	// Interface and decode checks; each compares a flopped output or stored field with its cause one cycle earlier.
	AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (!arst_n) // [RL1]
		reg_rd_en && !hit |=> reg_rdata == 8'h00)
		else $error("Unmapped read returned nonzero data.");
	AST_FOREIGN_WRITE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL1]
		reg_wr_en && !hit |=> $stable(code_r) && $stable(tol_r))
		else $error("Write to another address changed the register.");
	AST_READ_HOLD: assert property (@(posedge mclk) disable iff (!arst_n) // [RL1]
		arst_n && !reg_rd_en |=> $stable(reg_rdata))
		else $error("Read data changed without a read.");
	AST_READ_LAYOUT: assert property (@(posedge mclk) disable iff (!arst_n) // [RL6]
		reg_rd_en && hit |=> reg_rdata == {$past(code_r), $past(tol_r), 1'b0})
		else $error("Read data does not match stored fields.");
	AST_MIRROR_CODE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL2]
		arst_n |=> secondary_port_rate_code == $past(code_r) && secondary_rate_tolerance_sel == $past(tol_r))
		else $error("Stored fields not mirrored to outputs.");
	AST_DETECT_VALID: assert property (@(posedge mclk) disable iff (!arst_n) // [RL2]
		arst_n && code_r == SSRC_CODE_AUTO |=> active_rate_valid == $past(detected_valid))
		else $error("Auto mode not passing detector valid.");
	AST_AUTO_RANGE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL2]
		code_r == SSRC_CODE_AUTO |=> active_min_hz == '0 && active_max_hz == '0)
		else $error("Auto mode range not cleared.");
	AST_CODE_ONE_RATE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL3]
		code_r == 6'h01 |=> active_rate_hz == 20'd768000 && active_rate_valid)
		else $error("Code one rate wrong.");
	AST_FIXED_ORDER: assert property (@(posedge mclk) disable iff (!arst_n) // [RL3]
		code_r != SSRC_CODE_AUTO && code_r <= SSRC_CODE_MAX
		|=> active_min_hz < active_rate_hz && active_rate_hz < active_max_hz)
		else $error("Fixed rate outside its accepted range.");
	AST_NARROW_TOL: assert property (@(posedge mclk) disable iff (!arst_n) // [RL5]
		!tol_r |=> tolerance_pct == 8'h01)
		else $error("Narrow tolerance not applied.");
	AST_RESERVED_RATE: assert property (@(posedge mclk) disable iff (!arst_n) // [RL4]
		code_r > SSRC_CODE_MAX |=> active_rate_hz == '0 && active_min_hz == '0 && active_max_hz == '0)
		else $error("Reserved code left a rate active.");
endmodule : ssrc_config

// File: testbench/ssrc_config_tb.sv
// Self-checking bench for the secondary rate configuration register.
`timescale 1ns/1ns
module ssrc_config_tb import ssrc_pkg::*;;
	logic mclk = 1'h0;
	logic arst_n = 1'h0;
	logic reg_wr_en = 1'h0;
	logic reg_rd_en = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [SSRC_RATE_W-1:0] detected_rate_hz = 20'h0BB80;
	logic detected_valid = 1'h0;
	logic [7:0] reg_rdata, tolerance_pct, rd;
	logic [5:0] secondary_port_rate_code;
	logic secondary_rate_tolerance_sel, auto_detect_en, code_reserved, active_rate_valid;
	logic [SSRC_RATE_W-1:0] active_rate_hz, active_min_hz, active_max_hz;
	integer mismatches = 0, check_count = 0, seed = 51, m_reg = 0, i, d;
	int spot [3][4] = '{'{1, 768000, 670320, 791040}, '{20, 48000, 41895, 49440}, '{40, 3000, 2618, 3090}};

	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;

	ssrc_config u_ssrc_config (.mclk(mclk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .detected_rate_hz(detected_rate_hz),
		.detected_valid(detected_valid), .reg_rdata(reg_rdata), .secondary_port_rate_code(secondary_port_rate_code),
		.secondary_rate_tolerance_sel(secondary_rate_tolerance_sel), .auto_detect_en(auto_detect_en),
		.tolerance_pct(tolerance_pct), .code_reserved(code_reserved), .active_rate_hz(active_rate_hz),
		.active_min_hz(active_min_hz), .active_max_hz(active_max_hz), .active_rate_valid(active_rate_valid));

	// Case inequality so that an unknown output never passes for a match.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Write strobe lasts one cycle; the model keeps only bits 7-1 since bit 0 is read-only.
	task wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge mclk);
		reg_wr_en <= 1'h1;
		reg_addr <= a;
		reg_wdata <= dat;
		@(posedge mclk);
		reg_wr_en <= 1'h0;
		if (a == SSRC_OFFSET)
			m_reg = dat & 8'hFE;
		repeat (2) @(posedge mclk);
		#1;
	endtask : wr

	// Read data is registered, so it is sampled a cycle after the strobe is taken.
	task rd8(input logic [7:0] a);
		@(posedge mclk);
		reg_rd_en <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd_en <= 1'h0;
		@(posedge mclk);
		#1;
		rd = reg_rdata;
	endtask : rd8

	// Write followed at once by a read of the same address; the read must return the new value.
	task wr_rd(input logic [7:0] dat);
		@(posedge mclk);
		reg_wr_en <= 1'h1;
		reg_addr <= SSRC_OFFSET;
		reg_wdata <= dat;
		@(posedge mclk);
		reg_wr_en <= 1'h0;
		reg_rd_en <= 1'h1;
		m_reg = dat & 8'hFE;
		@(posedge mclk);
		reg_rd_en <= 1'h0;
		@(posedge mclk);
		#1;
		chk(reg_rdata, m_reg);
	endtask : wr_rd

	// Compares each decoded output with the model register; fixed-code rates are only checked for min < rate < max.
	task chk_all;
		rd8(SSRC_OFFSET);
		chk(rd, m_reg[7:0]);
		chk(secondary_port_rate_code, m_reg[7:2]);
		chk(secondary_rate_tolerance_sel, m_reg[1]);
		chk(auto_detect_en, m_reg[7:2] == 0);
		chk(tolerance_pct, m_reg[1] ? 5 : 1);
		chk(code_reserved, m_reg[7:2] > 40);
		chk(active_rate_valid, (m_reg[7:2] == 0) ? detected_valid : (m_reg[7:2] <= 40));
		if (m_reg[7:2] == 0)
			chk(active_rate_hz, detected_rate_hz);
		if (m_reg[7:2] > 40)
			chk(active_rate_hz, 0);
		if (m_reg[7:2] == 0 || m_reg[7:2] > 40)
		begin
			chk(active_min_hz, 0);
			chk(active_max_hz, 0);
		end
		else
			chk(active_min_hz < active_rate_hz && active_rate_hz < active_max_hz, 1);
	endtask : chk_all

	task report_and_stop;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// Main sequence: reset values, refused accesses, auto mode, fixed codes, reserved codes, random writes.
	initial
	begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'h1;
		chk_all;
		wr(8'h34, 8'hFF);
		wr(8'h32, 8'h55);
		chk_all;
		rd8(8'h34);
		chk(rd, 8'h00);
		wr(SSRC_OFFSET, 8'h02);
		chk_all;
		@(posedge mclk);
		detected_valid <= 1'h1;
		detected_rate_hz <= 20'h17700;
		repeat (3) @(posedge mclk);
		#1;
		chk_all;
		wr_rd(8'h52);
		chk_all;
		for (i = 0; i < 3; i++)
		begin
			wr(SSRC_OFFSET, 8'(spot[i][0] * 4 + 2));
			chk_all;
			chk(active_rate_hz, spot[i][1]);
			chk(active_min_hz, spot[i][2]);
			chk(active_max_hz, spot[i][3]);
		end
		wr(SSRC_OFFSET, 8'hA4);
		chk_all;
		chk(active_rate_hz, 20'h00000);
		wr(SSRC_OFFSET, 8'hFE);
		chk_all;
		for (i = 0; i < 16; i++)
		begin
			d = $random(seed);
			@(posedge mclk);
			detected_rate_hz <= 20'(d >> 8);
			detected_valid <= d[31];
			wr(SSRC_OFFSET, {6'(d[15:8] % 8'd41), d[1], 1'b0});
			chk_all;
		end
		// A second reset in mid-run must clear the register again.
		@(posedge mclk);
		arst_n <= 1'h0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'h1;
		m_reg = 0;
		chk_all;
		report_and_stop;
	end

	// Watchdog well beyond the few hundred cycles the sequence needs.
	initial
	begin
		#100000;
		mismatches++;
		report_and_stop;
	end
endmodule : ssrc_config_tb
